// ### verilog/bhph_power_ctrl.sv
// Top of the host power handshake and power state logic.
// Assumes LP_TICK is a synchronous one-cycle pulse at the low-power clock rate.
`timescale 1ns/1ps
`default_nettype none
module bhph_power_ctrl (
  input wire logic CLK,
  input wire logic RST,
  input wire logic DEV_WAKE_IN,
  output logic HOST_WAKE_OUT,
  output logic HOST_WAKE_OE,
  output logic REF_CLK_REQ_OUT,
  output logic REF_CLK_REQ_OE,
  output logic [2:0] PAD_FUNC_SEL,
  input wire logic UART_MODE,
  input wire logic HS_ENABLE,
  input wire logic DEV_WAKE_POL,
  input wire logic HOST_WAKE_POL,
  input wire logic SLEEP_OK,
  input wire logic ATTN_NEED,
  input wire logic BT_CLK_NEED,
  input wire logic WLAN_CLK_NEED,
  input wire logic LOWPOWER_REQ,
  input wire logic [15:0] WAKE_INTERVAL,
  input wire logic LP_TICK,
  input wire logic SHUTDOWN_REQ,
  input wire logic TX_ACTIVE,
  input wire logic RX_ACTIVE,
  input wire logic FM_ON,
  output logic TX_PD,
  output logic RX_PD,
  output logic PLL_PD,
  output logic PA_PD,
  output logic FM_PD,
  output logic LP_CLK_SEL,
  output logic INPUTS_EN,
  output logic [3:0] POWER_STATE
);
  bhph_pkg::bhph_state_t state_r;
  bhph_pkg::bhph_state_t state_nxt;
  logic dev_wake_sync;
  logic dev_wake_act;
  logic hs_on;
  logic [bhph_pkg::INTERVAL_W-1:0] cnt_r;
  logic interval_done;
  logic shutdown;
  logic wake_rise;
  logic host_wake_r;
  logic clk_req_r;
  logic [1:0] sync_fill_r;

  // Handshake usable only in UART mode with enable set
  assign hs_on = UART_MODE & HS_ENABLE;
  assign shutdown = (state_r == bhph_pkg::ST_SHUTDOWN);

  // Wake input through two flops before any use
  bhph_sync2 u_wake_sync (
    .clk(CLK),
    .rst(RST),
    .d(DEV_WAKE_IN),
    .q(dev_wake_sync)
  );

  // Synchroniser shows its reset value for two edges; with an active-low pin
  // that value reads as asserted, so the wake input stays masked until both
  // stages hold real pin samples, which also avoids a false edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync_fill_r <= bhph_pkg::SYNC_RST;
    end else begin
      sync_fill_r <= {sync_fill_r[0], 1'b1};
    end
  end

  // Polarity chosen by software; ignored when handshake off
  assign dev_wake_act = hs_on & sync_fill_r[1] & (dev_wake_sync ^ ~DEV_WAKE_POL);

  bhph_edge u_wake_edge (
    .clk(CLK),
    .rst(RST),
    .d(dev_wake_act),
    .rise(wake_rise)
  );

  // Sleep interval counter on low-power ticks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= bhph_pkg::INTERVAL_RST;
    end else if (state_r != bhph_pkg::ST_LOWPOWER) begin
      cnt_r <= bhph_pkg::INTERVAL_RST;
    end else if (LP_TICK && !interval_done) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  assign interval_done = (cnt_r >= WAKE_INTERVAL);

  // Power state selection
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      bhph_pkg::ST_ACTIVE: begin
        if (SHUTDOWN_REQ) begin
          state_nxt = bhph_pkg::ST_SHUTDOWN;
        end else if (!dev_wake_act && SLEEP_OK) begin
          state_nxt = LOWPOWER_REQ ? bhph_pkg::ST_LOWPOWER : bhph_pkg::ST_SLEEP;
        end
      end
      bhph_pkg::ST_SLEEP: begin
        if (SHUTDOWN_REQ) begin
          state_nxt = bhph_pkg::ST_SHUTDOWN;
        end else if (dev_wake_act || !SLEEP_OK) begin
          state_nxt = bhph_pkg::ST_ACTIVE;
        end
      end
      bhph_pkg::ST_LOWPOWER: begin
        if (SHUTDOWN_REQ) begin
          state_nxt = bhph_pkg::ST_SHUTDOWN;
        end else if (dev_wake_act || interval_done) begin
          state_nxt = bhph_pkg::ST_ACTIVE;
        end
      end
      bhph_pkg::ST_SHUTDOWN: begin
        if (!SHUTDOWN_REQ) begin
          state_nxt = bhph_pkg::ST_ACTIVE;
        end
      end
      default: state_nxt = bhph_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= bhph_pkg::ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Host wake and clock request; cleared in shutdown so nothing survives
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      host_wake_r <= 1'b0;
      clk_req_r <= 1'b0;
    end else if (shutdown) begin
      host_wake_r <= 1'b0;
      clk_req_r <= 1'b0;
    end else begin
      host_wake_r <= hs_on & ATTN_NEED;
      clk_req_r <= BT_CLK_NEED | WLAN_CLK_NEED;
    end
  end

  // Active-high clock request; host wake polarity per software
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HOST_WAKE_OUT <= 1'b0;
      REF_CLK_REQ_OUT <= 1'b0;
    end else begin
      HOST_WAKE_OUT <= host_wake_r ^ ~HOST_WAKE_POL;
      REF_CLK_REQ_OUT <= clk_req_r;
    end
  end

  // Outputs tristated, inputs disabled in shutdown
  assign HOST_WAKE_OE = hs_on & ~shutdown & sync_fill_r[1]; // Released until first level lands
  assign REF_CLK_REQ_OE = ~shutdown;
  assign INPUTS_EN = ~shutdown;
  assign PAD_FUNC_SEL = bhph_pkg::PAD_FUNC_VAL;

  // Radio power-downs, each separate, radio on only within packets
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TX_PD <= 1'b1;
      RX_PD <= 1'b1;
      PLL_PD <= 1'b1;
      PA_PD <= 1'b1;
    end else begin
      TX_PD <= !(state_r == bhph_pkg::ST_ACTIVE && TX_ACTIVE);
      RX_PD <= !(state_r == bhph_pkg::ST_ACTIVE && RX_ACTIVE);
      PLL_PD <= !(state_r == bhph_pkg::ST_ACTIVE && (TX_ACTIVE || RX_ACTIVE));
      PA_PD <= !(state_r == bhph_pkg::ST_ACTIVE && TX_ACTIVE);
    end
  end

  // FM is simply on or off, off in shutdown
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FM_PD <= 1'b1;
    end else begin
      FM_PD <= !(FM_ON && !shutdown);
    end
  end

  // Low-power clock selected in sniff/hold
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LP_CLK_SEL <= 1'b0;
    end else begin
      LP_CLK_SEL <= (state_nxt == bhph_pkg::ST_LOWPOWER);
    end
  end

  assign POWER_STATE = state_r;

  // Checks
  sequence s_wake_seen;
    wake_rise && !SHUTDOWN_REQ && state_r != bhph_pkg::ST_SHUTDOWN;
  endsequence

  chk_wake_to_active: assert property (@(posedge CLK) disable iff (RST)
    s_wake_seen |=> state_r == bhph_pkg::ST_ACTIVE)
    else $error("wake request did not bring device active");
  chk_sleep_needs_ok: assert property (@(posedge CLK) disable iff (RST)
    (state_r == bhph_pkg::ST_ACTIVE && state_nxt == bhph_pkg::ST_SLEEP) |-> SLEEP_OK && !dev_wake_act)
    else $error("sleep without criteria");
  chk_host_wake_lat: assert property (@(posedge CLK) disable iff (RST)
    (hs_on && ATTN_NEED && !shutdown && HOST_WAKE_POL) [*3] |-> HOST_WAKE_OUT)
    else $error("host wake not asserted");
  chk_hs_gate: assert property (@(posedge CLK) disable iff (RST)
    !hs_on |-> !HOST_WAKE_OE && !dev_wake_act)
    else $error("handshake active outside UART mode");
  chk_clk_req: assert property (@(posedge CLK) disable iff (RST)
    (BT_CLK_NEED && !shutdown) ##1 !shutdown |=> REF_CLK_REQ_OUT)
    else $error("clock request missing");
  chk_shutdown_tri: assert property (@(posedge CLK) disable iff (RST)
    shutdown |-> !HOST_WAKE_OE && !REF_CLK_REQ_OE && !INPUTS_EN)
    else $error("outputs driven in shutdown");
  chk_exit_clean: assert property (@(posedge CLK) disable iff (RST)
    $fell(shutdown) |-> !host_wake_r && !clk_req_r)
    else $error("state retained across shutdown");
  chk_pd_idle: assert property (@(posedge CLK) disable iff (RST)
    $past(state_r != bhph_pkg::ST_ACTIVE) |-> TX_PD && RX_PD && PLL_PD && PA_PD)
    else $error("radio powered while not active");
  chk_interval_wake: assert property (@(posedge CLK) disable iff (RST)
    (state_r == bhph_pkg::ST_LOWPOWER && interval_done && !SHUTDOWN_REQ)
      |=> state_r == bhph_pkg::ST_ACTIVE)
    else $error("no wake after interval");

  // Radio power-downs follow the packet phase one edge later
  sequence s_rx_only;
    state_r == bhph_pkg::ST_ACTIVE && RX_ACTIVE && !TX_ACTIVE;
  endsequence

  sequence s_tx_phase;
    state_r == bhph_pkg::ST_ACTIVE && TX_ACTIVE;
  endsequence

  chk_pd_separate: assert property (@(posedge CLK) disable iff (RST)
    s_rx_only |=> !RX_PD && !PLL_PD && TX_PD && PA_PD)
    else $error("receive path not powered on its own");
  chk_pd_tx_path: assert property (@(posedge CLK) disable iff (RST)
    s_tx_phase |=> !TX_PD && !PA_PD && !PLL_PD)
    else $error("transmit path not powered in packet");
  chk_pd_no_packet: assert property (@(posedge CLK) disable iff (RST)
    (!TX_ACTIVE && !RX_ACTIVE) |=> TX_PD && RX_PD && PLL_PD && PA_PD)
    else $error("radio powered outside packet");

  // FM has no third state: on, or off and powered down
  chk_fm_on: assert property (@(posedge CLK) disable iff (RST)
    (FM_ON && !shutdown) |=> !FM_PD)
    else $error("fm not powered when on");
  chk_fm_off: assert property (@(posedge CLK) disable iff (RST)
    (!FM_ON || shutdown) |=> FM_PD)
    else $error("fm powered when off");

  // Constant pad function; clock selection and count tied to the state
  chk_pad_zero: assert property (@(posedge CLK) disable iff (RST)
    PAD_FUNC_SEL == bhph_pkg::PAD_FUNC_VAL)
    else $error("pad function not zero");
  chk_lp_clk_sel: assert property (@(posedge CLK) disable iff (RST)
    LP_CLK_SEL == (state_r == bhph_pkg::ST_LOWPOWER))
    else $error("low-power clock select disagrees with state");
  chk_cnt_clear: assert property (@(posedge CLK) disable iff (RST)
    state_r != bhph_pkg::ST_LOWPOWER |=> cnt_r == bhph_pkg::INTERVAL_RST)
    else $error("interval count kept outside low power");

  // Wake pin keeps the device up; losing sleep criteria wakes it from sleep but not from low power
  chk_stay_awake: assert property (@(posedge CLK) disable iff (RST)
    (state_r == bhph_pkg::ST_ACTIVE && dev_wake_act && !SHUTDOWN_REQ)
      |=> state_r == bhph_pkg::ST_ACTIVE)
    else $error("device slept while wake requested");
  chk_sleep_lost: assert property (@(posedge CLK) disable iff (RST)
    (state_r == bhph_pkg::ST_SLEEP && !SLEEP_OK && !SHUTDOWN_REQ)
      |=> state_r == bhph_pkg::ST_ACTIVE)
    else $error("sleep kept without criteria");

  // Shutdown entry is immediate and exit restarts from the active state
  chk_sd_enter: assert property (@(posedge CLK) disable iff (RST)
    SHUTDOWN_REQ |=> shutdown)
    else $error("shutdown request not taken");
  chk_sd_exit: assert property (@(posedge CLK) disable iff (RST)
    (shutdown && !SHUTDOWN_REQ) |=> state_r == bhph_pkg::ST_ACTIVE)
    else $error("shutdown exit not to active");

  // Blocked handshake lets the host wake pin settle to its idle level
  sequence s_wake_blocked;
    !hs_on || shutdown;
  endsequence

  chk_hw_idle: assert property (@(posedge CLK) disable iff (RST)
    s_wake_blocked |-> ##2 (HOST_WAKE_OUT == !$past(HOST_WAKE_POL)))
    else $error("host wake asserted while handshake blocked");
  chk_host_wake_low: assert property (@(posedge CLK) disable iff (RST)
    (hs_on && ATTN_NEED && !shutdown && !HOST_WAKE_POL) [*3] |-> !HOST_WAKE_OUT)
    else $error("active-low host wake not asserted");
  chk_wake_masked: assert property (@(posedge CLK) disable iff (RST)
    !sync_fill_r[1] |-> !dev_wake_act && !HOST_WAKE_OE)
    else $error("wake pin used before synchroniser filled");

  // Clock request follows either requester, two edges late
  sequence s_wlan_need;
    WLAN_CLK_NEED && !shutdown;
  endsequence

  chk_clk_req_wlan: assert property (@(posedge CLK) disable iff (RST)
    s_wlan_need ##1 !shutdown |=> REF_CLK_REQ_OUT)
    else $error("clock request missing for wlan");
  chk_clk_req_off: assert property (@(posedge CLK) disable iff (RST)
    (!BT_CLK_NEED && !WLAN_CLK_NEED) |-> ##2 !REF_CLK_REQ_OUT)
    else $error("clock request without requester");
endmodule
`default_nettype wire

// ### verilog/bhph_pkg.sv
// Constants used by the host power handshake block, not by its helpers.
// Assumes a single 50 MHz clock; all controls arrive as plain ports.
package bhph_pkg;
  // Pad function value held for the handshake pins
  localparam logic [2:0] PAD_FUNC_VAL = 3'h0;
  // Sleep interval counter width (low-power clock ticks)
  localparam int INTERVAL_W = 16;
  // Reset values
  localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 16'h0000;
  localparam logic [1:0] SYNC_RST = 2'h0;

  // Power states, one-hot
  typedef enum logic [3:0] {
    ST_ACTIVE   = 4'h1,
    ST_SLEEP    = 4'h2,
    ST_LOWPOWER = 4'h4,
    ST_SHUTDOWN = 4'h8
  } bhph_state_t;
endpackage

// ### verilog/bhph_sync2.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is unrelated to CLK.
`timescale 1ns/1ps
`default_nettype none
module bhph_sync2 (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_r;
  // First stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### verilog/bhph_edge.sv
// Rising edge detector for a signal already on the CLK domain.
// Assumes the input is synchronous.
`timescale 1ns/1ps
`default_nettype none
module bhph_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic rise
);
  logic prev_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= d;
    end
  end
  assign rise = d & ~prev_r;
endmodule
`default_nettype wire

// ### verif/bhph_host_model.sv
// Behavioural host processor on the far side of the wake handshake.
// Assumes the bench supplies the host's own wake wish and sleep criteria.
`timescale 1ns/1ps
`default_nettype none
module bhph_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_wake_pin,
  input wire logic host_wake_oe,
  input wire logic host_pol,
  input wire logic dev_pol,
  input wire logic want_dev,
  input wire logic sleep_ok,
  output logic dev_wake_pin,
  output logic awake_r
);
  // Host drives its pin push-pull at all times, level set by polarity
  assign dev_wake_pin = want_dev ? dev_pol : ~dev_pol;
  // Wake while the device asks; a tristated pin never counts as asking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awake_r <= 1'b1;
    end else if (host_wake_oe && host_wake_pin == host_pol) begin
      awake_r <= 1'b1;
    end else if (sleep_ok) begin
      awake_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the host power handshake block.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst = 1, uart = 1, hs = 1, dpol = 1, hpol = 1, slp = 0, attn = 0;
  logic bt = 0, wl = 0, lpreq = 0, tick = 0, shut = 0, tx = 0, rx = 0, fm = 0, want = 0;
  logic [15:0] ivl = 16'h0000;
  logic dwake, hw, hwoe, rq, rqoe, txpd, rxpd, pllpd, papd, fmpd, lpsel, inen, awake;
  logic [2:0] pad;
  logic [3:0] st;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  bhph_power_ctrl DUT (.CLK(clk), .RST(rst), .DEV_WAKE_IN(dwake), .HOST_WAKE_OUT(hw),
    .HOST_WAKE_OE(hwoe), .REF_CLK_REQ_OUT(rq), .REF_CLK_REQ_OE(rqoe), .PAD_FUNC_SEL(pad),
    .UART_MODE(uart), .HS_ENABLE(hs), .DEV_WAKE_POL(dpol), .HOST_WAKE_POL(hpol),
    .SLEEP_OK(slp), .ATTN_NEED(attn), .BT_CLK_NEED(bt), .WLAN_CLK_NEED(wl),
    .LOWPOWER_REQ(lpreq), .WAKE_INTERVAL(ivl), .LP_TICK(tick), .SHUTDOWN_REQ(shut),
    .TX_ACTIVE(tx), .RX_ACTIVE(rx), .FM_ON(fm), .TX_PD(txpd), .RX_PD(rxpd), .PLL_PD(pllpd),
    .PA_PD(papd), .FM_PD(fmpd), .LP_CLK_SEL(lpsel), .INPUTS_EN(inen), .POWER_STATE(st));
  bhph_host_model host (.clk(clk), .rst(rst), .host_wake_pin(hw), .host_wake_oe(hwoe),
    .host_pol(hpol), .dev_pol(dpol), .want_dev(want), .sleep_ok(1'b1),
    .dev_wake_pin(dwake), .awake_r(awake));
  // 50 MHz clock
  always #10 clk = ~clk;
  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Sample just after an edge so its updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    chk("pd set", 4'hf, {txpd, rxpd, pllpd, papd});
    chk("fm pd", 4'h1, {3'h0, fmpd});
    chk("state", 4'h1, st);
    chk("pad", 4'h0, {1'b0, pad});
    chk("pins on", 4'h3, {2'h0, rqoe, inen});
  endtask
  // Both polarities of the host wake pin, with the host following it
  task automatic t_host_wake();
    for (int p = 0; p < 2; p++) begin
      @(posedge clk) hpol <= p[0];
      attn <= 1'b0;
      step(4);
      chk("hw idle", {3'h0, ~p[0]}, {3'h0, hw});
      chk("host slept", 4'h0, {3'h0, awake});
      @(posedge clk) attn <= 1'b1;
      step(4);
      chk("hw on", {3'h0, p[0]}, {3'h0, hw});
      chk("host awake", 4'h1, {3'h0, awake});
    end
    @(posedge clk) attn <= 1'b0;
    step(4);
  endtask
  // Sleep entry, synchronised wake, and the low-active wake pin
  task automatic t_sleep();
    @(posedge clk) slp <= 1'b1;
    step(3);
    chk("sleep", 4'h2, st);
    @(posedge clk) want <= 1'b1;
    step(1);
    chk("sync hold", 4'h2, st);
    step(3);
    chk("woken", 4'h1, st);
    step(4);
    chk("kept awake", 4'h1, st);
    @(posedge clk) dpol <= 1'b0;
    want <= 1'b0;
    step(6);
    chk("low pol sleep", 4'h2, st);
    @(posedge clk) want <= 1'b1;
    step(5);
    chk("low pol wake", 4'h1, st);
    @(posedge clk) dpol <= 1'b1;
    want <= 1'b0;
    slp <= 1'b0;
    step(4);
  endtask
  // Handshake must go dead outside UART mode or when disabled
  task automatic t_hs_off();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) hs <= i[0];
      uart <= ~i[0];
      slp <= 1'b1;
      want <= 1'b1;
      step(6);
      chk("wake ignored", 4'h2, st);
      chk("hw tristate", 4'h0, {3'h0, hwoe});
      @(posedge clk) hs <= 1'b1;
      uart <= 1'b1;
      want <= 1'b0;
      slp <= 1'b0;
      step(4);
    end
  endtask
  task automatic t_clk_req();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {bt, wl} <= i[1:0];
      step(4);
      chk("clk req", {3'h0, i != 0}, {3'h0, rq});
    end
  endtask
  // Every packet phase, then the two-state FM control
  task automatic t_radio();
    for (int i = 1; i < 5; i++) begin
      @(posedge clk) {tx, rx} <= i[1:0];
      step(3);
      chk("radio pd", {~i[1], ~i[0], ~(i[1] | i[0]), ~i[1]}, {txpd, rxpd, pllpd, papd});
    end
    @(posedge clk) fm <= 1'b1;
    step(3);
    chk("fm on", 4'h0, {3'h0, fmpd});
  endtask
  task automatic pulse();
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
  endtask
  // Low-power state counts three ticks before waking
  task automatic t_lowpower();
    logic seen;
    seen = 1'b0;
    @(posedge clk) ivl <= 16'h0003;
    lpreq <= 1'b1;
    slp <= 1'b1;
    tx <= 1'b1;
    step(4);
    chk("lp state", 4'h4, st);
    chk("lp radio off", 4'hf, {txpd, rxpd, pllpd, papd});
    chk("lp clk", 4'h1, {3'h0, lpsel});
    pulse();
    pulse();
    step(2);
    chk("lp counting", 4'h4, st);
    pulse();
    repeat (4) begin
      @(posedge clk);
      #1;
      if (st === 4'h1) seen = 1'b1;
    end
    chk("lp exit", 4'h1, {3'h0, seen});
    // Low power re-entered with a fresh count; only the wake pin gets it out now
    @(posedge clk) lpreq <= 1'b0;
    slp <= 1'b0;
    tx <= 1'b0;
    want <= 1'b1;
    step(4);
    chk("lp pin wake", 4'h1, st);
    @(posedge clk) want <= 1'b0;
    step(4);
  endtask
  // Shutdown tristates and forgets everything
  task automatic t_shutdown();
    @(posedge clk) attn <= 1'b1;
    bt <= 1'b1;
    shut <= 1'b1;
    step(4);
    chk("sd state", 4'h8, st);
    chk("sd oe", 4'h0, {2'h0, hwoe, rqoe});
    chk("sd inputs", 4'h0, {3'h0, inen});
    chk("sd cleared", 4'h0, {2'h0, hw, rq});
    @(posedge clk) attn <= 1'b0;
    bt <= 1'b0;
    fm <= 1'b0;
    {tx, rx} <= 2'h0;
    shut <= 1'b0;
    step(4);
    chk("sd exit", 4'h1, st);
    chk("sd clean", 4'h0, {2'h0, lpsel, hw});
    t_reset();
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    step(1);
    t_reset();
    t_host_wake();
    t_sleep();
    t_hs_off();
    t_clk_req();
    t_radio();
    t_lowpower();
    t_shutdown();
    finish_test();
  end
endmodule
`default_nettype wire
